//--- logic/ext_edge_detect.sv
// synchronisers and polarity-selected edge detectors for external interrupt pins
module ext_edge_detect
  import irq_flag_pkg::*;
(
  input  wire logic             clk_i,      // system clock
  input  wire logic             rst_i,      // synchronous reset, active high
  input  wire logic [EXT_N-1:0] pin_i,      // asynchronous external pins
  input  wire logic [EXT_N-1:0] polarity_i, // 1 falling edge, 0 rising edge
  output logic      [EXT_N-1:0] edge_o      // one-cycle pulse per detected edge
);

  logic [EXT_N-1:0] sync_a;
  logic [EXT_N-1:0] sync_b;
  logic [EXT_N-1:0] prev;
  logic [1:0]       arm_cnt;

  // chain runs through reset, so a pin held high reads as steady on release
  always_ff @(posedge clk_i) begin
    sync_a <= pin_i;
    sync_b <= sync_a;
  end

  // pin already high at reset must not look like a rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_cnt <= '0;
    end else if (arm_cnt != ARM_CYCLES) begin
      arm_cnt <= arm_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    prev <= sync_b;
    if (rst_i) begin
      edge_o <= '0;
    end else begin
      if (arm_cnt == ARM_CYCLES) begin
        edge_o <= (polarity_i & prev & ~sync_b) | (~polarity_i & ~prev & sync_b);
      end else begin
        edge_o <= '0;
      end
    end
  end

endmodule : ext_edge_detect

//--- logic/flag_register.sv
// one sixteen-bit request flag register, hardware set and software written
module flag_register
  import irq_flag_pkg::*;
#(
  parameter logic [REG_W-1:0] IMPL = '1 // implemented bit positions
) (
  input  wire logic             clk_i,   // system clock
  input  wire logic             rst_i,   // synchronous reset, active high
  input  wire logic [REG_W-1:0] set_i,   // hardware request pulses
  input  wire logic             wr_i,    // software write strobe
  input  wire logic [1:0]       be_i,    // byte enables for the write
  input  wire logic [REG_W-1:0] wdat_i,  // software write data
  output logic      [REG_W-1:0] flags_o, // current flag value
  output logic                  new_o    // pulse when a hardware request set any flag from 0 to 1
);

  logic [REG_W-1:0] wmask;
  logic [REG_W-1:0] next_flags;

  always_comb begin
    wmask      = {{8{be_i[1]}}, {8{be_i[0]}}} & IMPL;
    next_flags = flags_o;
    if (wr_i) begin
      next_flags = (flags_o & ~wmask) | (wdat_i & wmask);
    end
    // set beats a clear in the same cycle
    next_flags = (next_flags | set_i) & IMPL;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_o <= REG_RESET;
      new_o   <= 1'b0;
    end else begin
      flags_o <= next_flags;
      new_o   <= |(set_i & IMPL & ~flags_o);
    end
  end

endmodule : flag_register

//--- logic/irq_flag_ctrl.sv
// interrupt control register, first three flag registers and event interrupt
// ------------------------------------------------------------------------
// Summary of operation
// - control bit 15 set selects the alternate vector table, clear the default.
// - control bit 14 reads one while a timed interrupt disable is active.
// - control bits 0-4 pick falling (1) or rising (0) edge per ext input.
// - flags are set by hardware, reset to zero, and are software read/write.
// - flag register 0 holds adc, uart1, spi1, timers 1-3, oc1-2, ic1-2, ext0.
// - flag register 1 upper byte holds uart2, ext2, timers 4-5, oc3-4.
// - flag register 1 lower byte holds ic7-8, ext1, change, comparator, i2c1.
// - flag register 2 holds parallel port, oc5-8, ic3-6, spi2 event and fault.
// - unimplemented bits read zero and ignore writes.
// - flags set by their source, cleared only by software, in vector order.
// ------------------------------------------------------------------------
module irq_flag_ctrl
  import irq_flag_pkg::*;
(
  input  wire logic             clk_i,              // system clock, 125 MHz
  input  wire logic             rst_i,              // synchronous reset, active high
  // wishbone classic slave
  input  wire logic             wb_cyc_i,           // bus cycle
  input  wire logic             wb_stb_i,           // strobe
  input  wire logic             wb_we_i,            // write enable
  input  wire logic [7:0]       wb_adr_i,           // byte address
  input  wire logic [3:0]       wb_sel_i,           // byte lane selects
  input  wire logic [31:0]      wb_dat_i,           // write data
  output logic      [31:0]      wb_dat_o,           // read data
  output logic                  wb_ack_o,           // acknowledge
  // request sources
  input  wire periph_req_t      periph_req_i,       // peripheral request pulses
  input  wire logic [EXT_N-1:0] ext_irq_i,          // external interrupt pins
  input  wire logic             timed_irq_disable_i, // timed disable in progress
  // to the vector logic and cpu
  output logic                  alternate_vector_table_select_o, // alt table in use
  output logic      [REG_W-1:0] interrupt_flags_zero_o, // flag register 0
  output logic      [REG_W-1:0] interrupt_flags_one_o,  // flag register 1
  output logic      [REG_W-1:0] interrupt_flags_two_o,  // flag register 2
  output logic                  irq_o               // unmasked event pending
);

  // ----------------------------------------------------------------------
  // internal state
  // ----------------------------------------------------------------------
  logic                alternate_vector_table_select;
  logic                timed_irq_disable_active;
  logic [EXT_N-1:0]    ext_irq_edge_polarity;
  logic [EXT_N-1:0]    ext_edge;
  logic [REG_W-1:0]    interrupt_control_two;
  logic [REG_W-1:0]    set_zero;
  logic [REG_W-1:0]    set_one;
  logic [REG_W-1:0]    set_two;
  logic                new_zero;
  logic                new_one;
  logic                new_two;
  logic [EVT_W-1:0]    evt_status;
  logic [EVT_W-1:0]    evt_mask;
  logic [EVT_W-1:0]    evt_in;
  logic [EVT_W-1:0]    next_evt_status;
  logic [EVT_W-1:0]    next_evt_mask;
  logic                bus_req;
  logic                wr_commit;
  logic                wr_ctrl;
  logic                wr_zero;
  logic                wr_one;
  logic                wr_two;
  logic                wr_status;
  logic                wr_mask;
  logic [1:0]          wr_be;
  logic [31:0]         next_rdata;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_commit && (wb_adr_i == ofs);
  endfunction : wr_hit

  function automatic logic [REG_W-1:0] map_zero(input periph_req_t r, input logic ext0);
    logic [REG_W-1:0] v;
    v              = '0;
    v[F0_ADC_DONE] = r.adc_done;
    v[F0_UART1_TX] = r.uart1_tx;
    v[F0_UART1_RX] = r.uart1_rx;
    v[F0_SPI1_EVT] = r.spi1_event;
    v[F0_SPI1_FLT] = r.spi1_fault;
    v[F0_TIMER3]   = r.timer3;
    v[F0_TIMER2]   = r.timer2;
    v[F0_OC2]      = r.oc2;
    v[F0_IC2]      = r.ic2;
    v[F0_TIMER1]   = r.timer1;
    v[F0_OC1]      = r.oc1;
    v[F0_IC1]      = r.ic1;
    v[F0_EXT0]     = ext0;
    map_zero       = v;
  endfunction : map_zero

  function automatic logic [REG_W-1:0] map_one(input periph_req_t r, input logic ext1,
                                               input logic ext2);
    logic [REG_W-1:0] v;
    v              = '0;
    v[F1_UART2_TX] = r.uart2_tx;
    v[F1_UART2_RX] = r.uart2_rx;
    v[F1_EXT2]     = ext2;
    v[F1_TIMER5]   = r.timer5;
    v[F1_TIMER4]   = r.timer4;
    v[F1_OC4]      = r.oc4;
    v[F1_OC3]      = r.oc3;
    v[F1_IC8]      = r.ic8;
    v[F1_IC7]      = r.ic7;
    v[F1_EXT1]     = ext1;
    v[F1_CHANGE]   = r.change_notify;
    v[F1_COMPARE]  = r.comparator;
    v[F1_I2C1_MST] = r.i2c1_master;
    v[F1_I2C1_SLV] = r.i2c1_slave;
    map_one        = v;
  endfunction : map_one

  function automatic logic [REG_W-1:0] map_two(input periph_req_t r);
    logic [REG_W-1:0] v;
    v                        = '0;
    v[F2_PARALLEL]           = r.parallel_port;
    v[F2_OC_LSB +: 4]        = r.oc8_to_oc5;
    v[F2_IC_LSB +: 4]        = r.ic6_to_ic3;
    v[F2_SPI2_EVT]           = r.spi2_event;
    v[F2_SPI2_FLT]           = r.spi2_fault;
    map_two                  = v;
  endfunction : map_two

  // ----------------------------------------------------------------------
  // wishbone handshake
  // ----------------------------------------------------------------------
  // ack one cycle after the strobe; the write lands on the edge that sees ack
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_be     = wb_sel_i[1:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // strobes decoded in a process: a function in a port map is only
  // re-evaluated when its own arguments change, never on the bus
  always_comb begin
    wr_ctrl   = wr_hit(OFS_CONTROL_TWO);
    wr_zero   = wr_hit(OFS_FLAGS_ZERO);
    wr_one    = wr_hit(OFS_FLAGS_ONE);
    wr_two    = wr_hit(OFS_FLAGS_TWO);
    wr_status = wr_hit(OFS_EVT_STATUS) && wr_be[0];
    wr_mask   = wr_hit(OFS_EVT_MASK) && wr_be[0];
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alternate_vector_table_select <= 1'b0;
    end else if (wr_ctrl && wr_be[1]) begin
      alternate_vector_table_select <= wb_dat_i[CTRL_ALT_VECTOR_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_edge_polarity <= '0;
    end else if (wr_ctrl && wr_be[0]) begin
      ext_irq_edge_polarity <= wb_dat_i[CTRL_POL_LSB +: EXT_N];
    end
  end

  // status follows the cpu, software writes to it are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timed_irq_disable_active <= 1'b0;
    end else begin
      timed_irq_disable_active <= timed_irq_disable_i;
    end
  end

  always_comb begin
    interrupt_control_two                             = '0;
    interrupt_control_two[CTRL_ALT_VECTOR_BIT]        = alternate_vector_table_select;
    interrupt_control_two[CTRL_TIMED_OFF_BIT]         = timed_irq_disable_active;
    interrupt_control_two[CTRL_POL_LSB +: EXT_N]      = ext_irq_edge_polarity;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alternate_vector_table_select_o <= 1'b0;
    end else begin
      alternate_vector_table_select_o <= alternate_vector_table_select;
    end
  end

  // ----------------------------------------------------------------------
  // external inputs
  // ----------------------------------------------------------------------
  // a pin edge reaches its flag four edges after the pin moves
  ext_edge_detect u_ext_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (ext_irq_i),
    .polarity_i (ext_irq_edge_polarity),
    .edge_o     (ext_edge)
  );

  // ----------------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------------
  assign set_zero = map_zero(periph_req_i, ext_edge[0]);
  assign set_one  = map_one(periph_req_i, ext_edge[1], ext_edge[2]);
  assign set_two  = map_two(periph_req_i);

  flag_register #(
    .IMPL (FLAGS0_IMPL)
  ) u_flags_zero (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set_zero),
    .wr_i    (wr_zero),
    .be_i    (wr_be),
    .wdat_i  (wb_dat_i[REG_W-1:0]),
    .flags_o (interrupt_flags_zero_o),
    .new_o   (new_zero)
  );

  flag_register #(
    .IMPL (FLAGS1_IMPL)
  ) u_flags_one (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set_one),
    .wr_i    (wr_one),
    .be_i    (wr_be),
    .wdat_i  (wb_dat_i[REG_W-1:0]),
    .flags_o (interrupt_flags_one_o),
    .new_o   (new_one)
  );

  flag_register #(
    .IMPL (FLAGS2_IMPL)
  ) u_flags_two (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (set_two),
    .wr_i    (wr_two),
    .be_i    (wr_be),
    .wdat_i  (wb_dat_i[REG_W-1:0]),
    .flags_o (interrupt_flags_two_o),
    .new_o   (new_two)
  );

  // ----------------------------------------------------------------------
  // event status, mask and interrupt line
  // ----------------------------------------------------------------------
  // ext 3 and 4 have their flags elsewhere, so only their edges land here
  always_comb begin
    evt_in             = '0;
    evt_in[EVT_FLAGS0] = new_zero;
    evt_in[EVT_FLAGS1] = new_one;
    evt_in[EVT_FLAGS2] = new_two;
    evt_in[EVT_EXT3]   = ext_edge[3];
    evt_in[EVT_EXT4]   = ext_edge[4];
  end

  always_comb begin
    next_evt_status    = evt_status;
    if (wr_status) begin
      next_evt_status = evt_status & ~wb_dat_i[EVT_W-1:0];
    end
    // a new event wins over a write-one clear in the same cycle
    next_evt_status = next_evt_status | evt_in;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_status <= EVT_RESET;
    end else begin
      evt_status <= next_evt_status;
    end
  end

  // the line follows a mask write on the same edge as the mask itself,
  // so software sees no stale request after masking
  always_comb begin
    next_evt_mask = evt_mask;
    if (wr_mask) begin
      next_evt_mask = wb_dat_i[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_mask <= EVT_RESET;
    end else begin
      evt_mask <= next_evt_mask;
    end
  end

  // registered so the line cannot glitch while status decodes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_evt_status & next_evt_mask);
    end
  end

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // unmapped offsets answer with ack and zero data
  always_comb begin
    next_rdata = '0;
    case (wb_adr_i)
      OFS_CONTROL_TWO: next_rdata[REG_W-1:0] = interrupt_control_two;
      OFS_FLAGS_ZERO:  next_rdata[REG_W-1:0] = interrupt_flags_zero_o;
      OFS_FLAGS_ONE:   next_rdata[REG_W-1:0] = interrupt_flags_one_o;
      OFS_FLAGS_TWO:   next_rdata[REG_W-1:0] = interrupt_flags_two_o;
      OFS_EVT_STATUS:  next_rdata[EVT_W-1:0] = evt_status;
      OFS_EVT_MASK:    next_rdata[EVT_W-1:0] = evt_mask;
      default:         next_rdata = '0;
    endcase
  end

  // read data stands for the ack cycle only, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= next_rdata;
    end else begin
      wb_dat_o <= '0;
    end
  end

endmodule : irq_flag_ctrl

//--- logic/irq_flag_pkg.sv
// constants, field positions and source carrier for the interrupt flag block
package irq_flag_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets on the wishbone bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h00;
  localparam logic [7:0] OFS_FLAGS_ZERO  = 8'h04;
  localparam logic [7:0] OFS_FLAGS_ONE   = 8'h08;
  localparam logic [7:0] OFS_FLAGS_TWO   = 8'h0c;
  localparam logic [7:0] OFS_EVT_STATUS  = 8'h10;
  localparam logic [7:0] OFS_EVT_MASK    = 8'h14;

  // ----------------------------------------------------------------------
  // widths, masks and reset values
  // ----------------------------------------------------------------------
  localparam int          REG_W          = 16;
  localparam int          EXT_N          = 5;
  localparam int          EVT_W          = 5;
  localparam logic [15:0] CTRL_WR_MASK   = 16'h801f;
  localparam logic [15:0] FLAGS0_IMPL    = 16'h3fef;
  localparam logic [15:0] FLAGS1_IMPL    = 16'hfedf;
  localparam logic [15:0] FLAGS2_IMPL    = 16'h3fe3;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [4:0]  EVT_RESET      = 5'h00;
  localparam logic [1:0]  ARM_CYCLES     = 2'h2;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_ALT_VECTOR_BIT = 15;
  localparam int CTRL_TIMED_OFF_BIT  = 14;
  localparam int CTRL_POL_LSB        = 0;

  localparam int F0_ADC_DONE  = 13;
  localparam int F0_UART1_TX  = 12;
  localparam int F0_UART1_RX  = 11;
  localparam int F0_SPI1_EVT  = 10;
  localparam int F0_SPI1_FLT  = 9;
  localparam int F0_TIMER3    = 8;
  localparam int F0_TIMER2    = 7;
  localparam int F0_OC2       = 6;
  localparam int F0_IC2       = 5;
  localparam int F0_TIMER1    = 3;
  localparam int F0_OC1       = 2;
  localparam int F0_IC1       = 1;
  localparam int F0_EXT0      = 0;

  localparam int F1_UART2_TX  = 15;
  localparam int F1_UART2_RX  = 14;
  localparam int F1_EXT2      = 13;
  localparam int F1_TIMER5    = 12;
  localparam int F1_TIMER4    = 11;
  localparam int F1_OC4       = 10;
  localparam int F1_OC3       = 9;
  localparam int F1_IC8       = 7;
  localparam int F1_IC7       = 6;
  localparam int F1_EXT1      = 4;
  localparam int F1_CHANGE    = 3;
  localparam int F1_COMPARE   = 2;
  localparam int F1_I2C1_MST  = 1;
  localparam int F1_I2C1_SLV  = 0;

  localparam int F2_PARALLEL  = 13;
  localparam int F2_OC_LSB    = 9;
  localparam int F2_IC_LSB    = 5;
  localparam int F2_SPI2_EVT  = 1;
  localparam int F2_SPI2_FLT  = 0;

  // event status bits: one per flag register, plus edges of ext inputs 3 and 4
  localparam int EVT_FLAGS0   = 0;
  localparam int EVT_FLAGS1   = 1;
  localparam int EVT_FLAGS2   = 2;
  localparam int EVT_EXT3     = 3;
  localparam int EVT_EXT4     = 4;

  // ----------------------------------------------------------------------
  // request strobes from on-chip peripherals, one clock pulse each
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       adc_done;
    logic       uart1_tx;
    logic       uart1_rx;
    logic       spi1_event;
    logic       spi1_fault;
    logic       timer3;
    logic       timer2;
    logic       oc2;
    logic       ic2;
    logic       timer1;
    logic       oc1;
    logic       ic1;
    logic       uart2_tx;
    logic       uart2_rx;
    logic       timer5;
    logic       timer4;
    logic       oc4;
    logic       oc3;
    logic       ic8;
    logic       ic7;
    logic       change_notify;
    logic       comparator;
    logic       i2c1_master;
    logic       i2c1_slave;
    logic       parallel_port;
    logic [3:0] oc8_to_oc5;
    logic [3:0] ic6_to_ic3;
    logic       spi2_event;
    logic       spi2_fault;
  } periph_req_t;

endpackage : irq_flag_pkg

//--- test/irq_flag_checker.sv
// concurrent checks on the ports of the interrupt flag block
module irq_flag_checker
  import irq_flag_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire periph_req_t      periph_req_i,
  input wire logic             timed_irq_disable_i,
  input wire logic             alternate_vector_table_select_o,
  input wire logic [REG_W-1:0] interrupt_flags_zero_o,
  input wire logic [REG_W-1:0] interrupt_flags_one_o,
  input wire logic [REG_W-1:0] interrupt_flags_two_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  upper_zero_a: assert property (wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits not zero");

  // ----------------------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------------------
  unimpl_zero_a: assert property (interrupt_flags_zero_o[15:14] == 2'h0 &&
    !interrupt_flags_zero_o[4] && !interrupt_flags_one_o[8] && !interrupt_flags_one_o[5]
    && interrupt_flags_two_o[15:14] == 2'h0 && interrupt_flags_two_o[4:2] == 3'h0)
    else $error("unimplemented flag bit set");
  adc_set_a: assert property (periph_req_i.adc_done |=> interrupt_flags_zero_o[13])
    else $error("adc request did not set its flag");
  uart2_set_a: assert property (periph_req_i.uart2_tx |=> interrupt_flags_one_o[15])
    else $error("uart2 transmit request did not set its flag");
  i2c_slave_set_a: assert property (periph_req_i.i2c1_slave |=> interrupt_flags_one_o[0])
    else $error("i2c slave request did not set its flag");
  parallel_set_a: assert property (periph_req_i.parallel_port |=> interrupt_flags_two_o[13])
    else $error("parallel port request did not set its flag");
  // the adc flag (register 0 bit 13) may only drop at the edge that commits a software write to flag register 0
  sw_clear_a: assert property ($fell(interrupt_flags_zero_o[13]) |->
    $past(wb_ack_o && wb_we_i && wb_adr_i == OFS_FLAGS_ZERO))
    else $error("flag cleared without software write");

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  alt_copy_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_CONTROL_TWO |->
    wb_dat_o[15] == alternate_vector_table_select_o)
    else $error("vector table select differs from control bit");
  timed_off_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == OFS_CONTROL_TWO |->
    wb_dat_o[14] == $past(timed_irq_disable_i, 2))
    else $error("timed disable status bit wrong");
endmodule : irq_flag_checker

bind irq_flag_ctrl irq_flag_checker u_irq_flag_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_req_i(periph_req_i),
  .timed_irq_disable_i(timed_irq_disable_i),
  .alternate_vector_table_select_o(alternate_vector_table_select_o),
  .interrupt_flags_zero_o(interrupt_flags_zero_o), .interrupt_flags_one_o(interrupt_flags_one_o),
  .interrupt_flags_two_o(interrupt_flags_two_o));

//--- test/irq_source_model.sv
// peripherals and external pins that raise requests into the flag block
module irq_source_model
  import irq_flag_pkg::*;
(
  input  wire logic             clk_i,  // system clock
  output periph_req_t           req_o,  // one-cycle request pulses
  output logic      [EXT_N-1:0] pin_o   // external interrupt pins, idle low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_o = '0;
    pin_o = '0;
  end
  // sources only ever raise a request; clearing is left to software
  task pulse(input periph_req_t r);
    @(posedge clk_i);
    req_o <= r;
    @(posedge clk_i);
    req_o <= '0;
  endtask : pulse
  task set_pins(input logic [EXT_N-1:0] v);
    @(posedge clk_i);
    pin_o <= v;
    repeat (6) @(posedge clk_i);
  endtask : set_pins
endmodule : irq_source_model

//--- test/test_irq_flag_ctrl.sv
// register-level testbench for the interrupt flag block
module test_irq_flag_ctrl;
  import irq_flag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tdis = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, alt, irq;
  logic [REG_W-1:0] f0, f1, f2;
  periph_req_t req;
  logic [EXT_N-1:0] pins;
  int n_errors = 0, cmp_count = 0;
  always #4 clk_i = ~clk_i;

  irq_source_model u_irq_source_model (.clk_i(clk_i), .req_o(req), .pin_o(pins));
  irq_flag_ctrl u_irq_flag_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .periph_req_i(req), .ext_irq_i(pins), .timed_irq_disable_i(tdis),
    .alternate_vector_table_select_o(alt), .interrupt_flags_zero_o(f0),
    .interrupt_flags_one_o(f1), .interrupt_flags_two_o(f2), .irq_o(irq));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task finish_test;
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // request held until ack is sampled high, then released for a cycle
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      finish_test;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task rd(input string name, input logic [7:0] a, input logic [15:0] exp);
    wb(1'b0, a, 16'h0);
    check(name, q, {16'h0, exp});
  endtask : rd

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, unmapped place included
    for (int i = 0; i < 7; i++) rd("reset", 8'(4 * i), 16'h0);
    // control: read-only status and reserved bits ignore writes
    wb(1'b1, OFS_CONTROL_TWO, 16'hffff);
    rd("ctrl", OFS_CONTROL_TWO, 16'h801f);
    check("alt", alt, 1'b1);
    tdis <= 1'b1;
    rd("timed_off", OFS_CONTROL_TWO, 16'hc01f);
    tdis <= 1'b0;
    wb(1'b1, OFS_CONTROL_TWO, 16'h0000);
    rd("ctrl0", OFS_CONTROL_TWO, 16'h0000);
    check("alt0", alt, 1'b0);
    // every peripheral at once lands only on its own positions
    u_irq_source_model.pulse('1);
    rd("f0", OFS_FLAGS_ZERO, 16'h3fee);
    rd("f1", OFS_FLAGS_ONE, 16'hdecf);
    rd("f2", OFS_FLAGS_TWO, 16'h3fe3);
    for (int i = 1; i < 4; i++) begin
      wb(1'b1, 8'(4 * i), 16'h0000);
      rd("clr", 8'(4 * i), 16'h0000);
      wb(1'b1, 8'(4 * i), 16'hffff);
    end
    rd("w0", OFS_FLAGS_ZERO, 16'h3fef);
    rd("w1", OFS_FLAGS_ONE, 16'hfedf);
    rd("w2", OFS_FLAGS_TWO, 16'h3fe3);
    for (int i = 1; i < 4; i++) wb(1'b1, 8'(4 * i), 16'h0000);
    wb(1'b1, OFS_EVT_STATUS, 16'h001f);
    rd("st0", OFS_EVT_STATUS, 16'h0000);
    // rising edges on ext pins 0, 2, 3 and 4
    u_irq_source_model.set_pins(5'h1d);
    rd("ext0", OFS_FLAGS_ZERO, 16'h0001);
    rd("ext2", OFS_FLAGS_ONE, 16'h2000);
    rd("evt", OFS_EVT_STATUS, 16'h001b);
    check("irq_masked", irq, 1'b0);
    wb(1'b1, OFS_EVT_MASK, 16'h0001);
    @(posedge clk_i);
    check("irq_on", irq, 1'b1);
    wb(1'b1, OFS_EVT_STATUS, 16'h001b);
    @(posedge clk_i);
    check("irq_off", irq, 1'b0);
    rd("st1", OFS_EVT_STATUS, 16'h0000);
    // ext1 on falling polarity: rise ignored, fall counted
    wb(1'b1, OFS_CONTROL_TWO, 16'h0002);
    u_irq_source_model.set_pins(5'h1f);
    rd("ext1_rise", OFS_FLAGS_ONE, 16'h2000);
    u_irq_source_model.set_pins(5'h1d);
    rd("ext1_fall", OFS_FLAGS_ONE, 16'h2010);
    // reset again with pins 0, 2, 3 and 4 high: no false edge may follow
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd("rst_f0", OFS_FLAGS_ZERO, 16'h0000);
    rd("rst_f1", OFS_FLAGS_ONE, 16'h0000);
    rd("rst_evt", OFS_EVT_STATUS, 16'h0000);
    finish_test;
  end
endmodule : test_irq_flag_ctrl
